// file: rtl/smcs_clkdiv.sv
`timescale 1ns/100ps
`default_nettype none
module smcs_clkdiv
  import smcs_pkg::*;
#(
  parameter int DIV_W = SMCS_DIV_W
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  sclk,
  output logic                  rise,
  output logic                  fall
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             sclk;
  } smcs_div_state_t;

  smcs_div_state_t state_reg;
  smcs_div_state_t state_next;
  logic            tick;

  // ==========================================================
  // Half period counter
  assign tick = run && (state_reg.cnt == divisor);

  always_comb
  begin
    state_next = state_reg;
    if (!run)
    begin
      // Idle clock parks low so every word starts on a rising edge
      state_next.cnt  = '0;
      state_next.sclk = 1'b0;
    end
    else if (tick)
    begin
      state_next.cnt  = '0;
      state_next.sclk = ~state_reg.sclk;
    end
    else
    begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign sclk = state_reg.sclk;
  assign rise = tick && !state_reg.sclk;
  assign fall = tick && state_reg.sclk;

endmodule
`default_nettype wire

// file: rtl/smcs_select.sv
`timescale 1ns/100ps
`default_nettype none
module smcs_select
  import smcs_pkg::*;
#(
  parameter int SEL_W = SMCS_SEL_W
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [SEL_W-1:0] line_bits,
  input  wire logic             auto_en,
  input  wire logic             active_level,
  input  wire logic             word_active,
  output logic      [SEL_W-1:0] ss_out
);

  typedef struct packed {
    logic [SEL_W-1:0] ss;
  } smcs_ss_state_t;

  smcs_ss_state_t   state_reg;
  smcs_ss_state_t   state_next;
  logic [SEL_W-1:0] asserted;

  // ==========================================================
  // Select line drive
  always_comb
  begin
    if (auto_en)
      asserted = line_bits & {SEL_W{word_active}};
    else
      asserted = line_bits;
    state_next.ss = active_level ? asserted : ~asserted;
  end

  // Reset level is inactive for the reset polarity (active low)
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg.ss <= {SEL_W{1'b1}};
    else
      state_reg <= state_next;
  end

  assign ss_out = state_reg.ss;

endmodule
`default_nettype wire

// file: rtl/smcs_top.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module smcs_top
  import smcs_pkg::*;
#(
  parameter int DIV_W = SMCS_DIV_W
)(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [31:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             SERIAL_CLOCK_OUT,
  output logic       [1:0] SLAVE_SELECT_OUT,
  output logic             SERIAL_DATA_OUT,
  input  wire logic        SERIAL_DATA_IN
);

  // ==========================================================
  // State
  typedef struct packed {
    smcs_state_t                     st;
    smcs_ctrl_t                      ctrl;
    logic [DIV_W-1:0]                div;
    smcs_sel_t                       sel;
    logic [SMCS_WORDS-1:0][31:0]     data;
    logic [1:0]                      word;
    logic [5:0]                      bit_idx;
    logic [DIV_W-1:0]                gap_cnt;
    logic                            so;
    logic [31:0]                     rdata;
  } smcs_top_state_t;

  smcs_top_state_t state_reg;
  smcs_top_state_t state_next;
  logic      [1:0] rst_sync_reg;
  logic            rst_n;
  logic            run;
  logic            sclk;
  logic            rise;
  logic            fall;
  logic            idle;
  logic            data_hit;
  logic      [1:0] data_idx;
  logic      [5:0] last_bit;
  logic      [4:0] rx_pos;
  logic      [4:0] tx_pos;
  logic      [4:0] first_pos;

  // ==========================================================
  // Reset release
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // Decode helpers
  assign idle     = (state_reg.st == SMCS_IDLE);
  assign data_hit = (ADDR[31:4] == SMCS_DATA0_ADDR[31:4]);
  assign data_idx = ADDR[3:2];
  assign last_bit = smcs_word_bits(state_reg.ctrl.word_bit_count) - 6'h01;
  assign rx_pos   = smcs_bit_pos(state_reg.bit_idx,
                                 state_reg.ctrl.word_bit_count,
                                 state_reg.ctrl.lsb_first);
  assign tx_pos   = smcs_bit_pos(state_reg.bit_idx + 6'h01,
                                 state_reg.ctrl.word_bit_count,
                                 state_reg.ctrl.lsb_first);
  assign first_pos = smcs_bit_pos(6'h00,
                                  WDATA[SMCS_CTRL_LEN_LSB +: 5],
                                  WDATA[SMCS_CTRL_LSB_BIT]);

  // Serial clock runs only while a word is on the line
  assign run = (state_reg.st == SMCS_WORD);

  // ==========================================================
  // Next state
  always_comb
  begin
    state_next       = state_reg;
    state_next.rdata = 32'h0000_0000;

    // Register reads, answered one cycle later
    if (RD)
    begin
      if (ADDR == SMCS_CTRL_ADDR)
      begin
        state_next.rdata[SMCS_CTRL_GO_BIT]       = !idle;
        state_next.rdata[SMCS_CTRL_LEN_LSB +: 5] = state_reg.ctrl.word_bit_count;
        state_next.rdata[SMCS_CTRL_CNT_LSB +: 2] = state_reg.ctrl.word_count;
        state_next.rdata[SMCS_CTRL_LSB_BIT]      = state_reg.ctrl.lsb_first;
      end
      else if (ADDR == SMCS_DIV_ADDR)
      begin
        state_next.rdata[SMCS_DIV_LSB +: DIV_W] = state_reg.div;
      end
      else if (ADDR == SMCS_SEL_ADDR)
      begin
        state_next.rdata[SMCS_SEL_BITS_LSB +: SMCS_SEL_W] =
          state_reg.sel.select_line_bits;
        state_next.rdata[SMCS_SEL_LEVEL_BIT] = state_reg.sel.select_active_level;
        state_next.rdata[SMCS_SEL_AUTO_BIT]  = state_reg.sel.auto_select_enable;
      end
      else if (data_hit)
      begin
        state_next.rdata = state_reg.data[data_idx];
      end
    end

    // Writes take effect only between transfers; a busy port ignores them
    if (WR && idle)
    begin
      if (ADDR == SMCS_CTRL_ADDR)
      begin
        state_next.ctrl.word_bit_count = WDATA[SMCS_CTRL_LEN_LSB +: 5];
        state_next.ctrl.word_count     = WDATA[SMCS_CTRL_CNT_LSB +: 2];
        state_next.ctrl.lsb_first      = WDATA[SMCS_CTRL_LSB_BIT];
        if (WDATA[SMCS_CTRL_GO_BIT])
        begin
          // Launch uses the fields written in the same cycle
          state_next.st      = SMCS_WORD;
          state_next.word    = 2'b00;
          state_next.bit_idx = 6'h00;
          state_next.so      = state_reg.data[0][first_pos];
        end
      end
      else if (ADDR == SMCS_DIV_ADDR)
      begin
        state_next.div = WDATA[SMCS_DIV_LSB +: DIV_W];
      end
      else if (ADDR == SMCS_SEL_ADDR)
      begin
        state_next.sel.select_line_bits    = WDATA[SMCS_SEL_BITS_LSB +: SMCS_SEL_W];
        state_next.sel.select_active_level = WDATA[SMCS_SEL_LEVEL_BIT];
        state_next.sel.auto_select_enable  = WDATA[SMCS_SEL_AUTO_BIT];
      end
      else if (data_hit)
      begin
        // Same flops serve transmit and receive
        state_next.data[data_idx] = WDATA;
      end
    end

    // Word sequencing
    unique case (state_reg.st)
      SMCS_IDLE:
      begin
      end
      SMCS_WORD:
      begin
        if (rise)
        begin
          // Received bit overwrites the bit just sent from the same place
          state_next.data[state_reg.word][rx_pos] = SERIAL_DATA_IN;
        end
        if (fall)
        begin
          if (state_reg.bit_idx == last_bit)
          begin
            state_next.bit_idx = 6'h00;
            state_next.gap_cnt = '0;
            if (state_reg.word == state_reg.ctrl.word_count)
              state_next.st = SMCS_IDLE;
            else
              state_next.st = SMCS_GAP;
          end
          else
          begin
            state_next.bit_idx = state_reg.bit_idx + 6'h01;
            state_next.so      = state_reg.data[state_reg.word][tx_pos];
          end
        end
      end
      SMCS_GAP:
      begin
        // Select drops for half a serial period between words
        if (state_reg.gap_cnt == state_reg.div)
        begin
          state_next.st   = SMCS_WORD;
          state_next.word = state_reg.word + 2'b01;
          state_next.so   = state_reg.data[state_reg.word + 2'b01][rx_pos];
        end
        else
        begin
          state_next.gap_cnt = state_reg.gap_cnt + 1'b1;
        end
      end
      default:
      begin
        // Unused code, e.g. after an upset, returns to idle
        state_next.st = SMCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg         <= '0;
      state_reg.st      <= SMCS_IDLE;
      state_reg.ctrl    <= smcs_ctrl_t'(SMCS_CTRL_RST[10:3]);
      state_reg.div     <= SMCS_DIV_RST[DIV_W-1:0];
      state_reg.sel     <= smcs_sel_t'(SMCS_SEL_RST[3:0]);
      state_reg.data    <= {SMCS_WORDS{SMCS_DATA_RST}};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Serial clock and slave selects
  smcs_clkdiv #(
    .DIV_W   (DIV_W)
  ) u_clkdiv (
    .clk     (CLK),
    .rst_n   (rst_n),
    .run     (run),
    .divisor (state_reg.div),
    .sclk    (sclk),
    .rise    (rise),
    .fall    (fall)
  );

  smcs_select #(
    .SEL_W        (SMCS_SEL_W)
  ) u_select (
    .clk          (CLK),
    .rst_n        (rst_n),
    .line_bits    (state_reg.sel.select_line_bits),
    .auto_en      (state_reg.sel.auto_select_enable),
    .active_level (state_reg.sel.select_active_level),
    .word_active  (run),
    .ss_out       (SLAVE_SELECT_OUT)
  );

  // ==========================================================
  // Outputs
  assign RDATA            = state_reg.rdata;
  assign SERIAL_CLOCK_OUT = sclk;
  assign SERIAL_DATA_OUT  = state_reg.so;

endmodule
`default_nettype wire

// file: shared/smcs_pkg.sv
// Function
// - Serial clock is peripheral clock over 2(divisor+1)
// - Manual mode: selects follow software writes only
// - Auto mode: select per word, launched by go
// - Active level bit sets select polarity
// - Manual: one drives line active, zero inactive
// - Auto: marked line active only during words
// - Receive words hold last transfer data
// - Only low word-length bits are meaningful
// - Receive words read-only; writes update transmit; here a write lands in the shared word and reads back
// - Go starts transfer, stays set, self-clears
// - Length field 1..31 direct, zero is 32
// - Count field 00..11 gives one..four words
// - Shared storage: received data sent next time
`default_nettype none
package smcs_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] SMCS_CTRL_ADDR  = 32'hB800_6200;
  localparam logic [31:0] SMCS_DIV_ADDR   = 32'hB800_6204;
  localparam logic [31:0] SMCS_SEL_ADDR   = 32'hB800_6208;
  localparam logic [31:0] SMCS_DATA0_ADDR = 32'hB800_6210;
  localparam logic [31:0] SMCS_DATA1_ADDR = 32'hB800_6214;
  localparam logic [31:0] SMCS_DATA2_ADDR = 32'hB800_6218;
  localparam logic [31:0] SMCS_DATA3_ADDR = 32'hB800_621C;

  // ==========================================================
  // Field positions
  localparam int SMCS_CTRL_GO_BIT   = 0;
  localparam int SMCS_CTRL_LEN_LSB  = 3;
  localparam int SMCS_CTRL_CNT_LSB  = 8;
  localparam int SMCS_CTRL_LSB_BIT  = 10;
  localparam int SMCS_DIV_LSB       = 0;
  localparam int SMCS_SEL_BITS_LSB  = 0;
  localparam int SMCS_SEL_LEVEL_BIT = 2;
  localparam int SMCS_SEL_AUTO_BIT  = 3;

  // ==========================================================
  // Reset values and sizes
  localparam logic [31:0] SMCS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SMCS_DIV_RST  = 32'h0000_0000;
  localparam logic [31:0] SMCS_SEL_RST  = 32'h0000_0000;
  localparam logic [31:0] SMCS_DATA_RST = 32'h0000_0000;
  localparam int          SMCS_DIV_W    = 16;
  localparam int          SMCS_WORDS    = 4;
  localparam int          SMCS_SEL_W    = 2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SMCS_IDLE,
    SMCS_WORD,
    SMCS_GAP
  } smcs_state_t;

  typedef struct packed {
    logic       lsb_first;
    logic [1:0] word_count;
    logic [4:0] word_bit_count;
  } smcs_ctrl_t;

  typedef struct packed {
    logic                  auto_select_enable;
    logic                  select_active_level;
    logic [SMCS_SEL_W-1:0] select_line_bits;
  } smcs_sel_t;

  // ==========================================================
  // Shared arithmetic
  function automatic logic [5:0] smcs_word_bits(input logic [4:0] len);
    return (len == 5'h00) ? 6'h20 : {1'b0, len};
  endfunction

  function automatic logic [4:0] smcs_bit_pos(input logic [5:0] idx,
                                              input logic [4:0] len,
                                              input logic       lsb);
    logic [5:0] p;
    p = smcs_word_bits(len) - idx - 6'h01;
    return lsb ? idx[4:0] : p[4:0];
  endfunction

endpackage
`default_nettype wire

// file: sim/serial_master_clock_select_rx_test.sv
`timescale 1ns/100ps
`default_nettype none
module serial_master_clock_select_rx_test;
  import smcs_pkg::*;
  logic        clk, rst_n, wr, rd, si, sclk, so, lvl_m;
  logic [31:0] addr, wdata, rdata, mword;
  logic [1:0]  ss;
  logic [15:0] rises;
  int          errors, comparisons, cycles;

  smcs_top #(.DIV_W(SMCS_DIV_W)) DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SERIAL_CLOCK_OUT(sclk), .SLAVE_SELECT_OUT(ss),
    .SERIAL_DATA_OUT(so), .SERIAL_DATA_IN(si));
  smcs_slave_model u_slave (.clk(clk), .sclk(sclk), .ss(ss), .level(lvl_m), .so(so), .si(si),
    .rises(rises), .word(mword));

  // ==========================================================
  // Clock, timeout, reporting
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ==========================================================
  // Register bus
  task wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    logic [31:0] d;
    rd_reg(SMCS_CTRL_ADDR, d);
    chk(d, SMCS_CTRL_RST);
    rd_reg(SMCS_DIV_ADDR, d);
    chk(d, SMCS_DIV_RST);
    rd_reg(SMCS_SEL_ADDR, d);
    chk(d, SMCS_SEL_RST);
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(SMCS_DATA0_ADDR + 32'(4 * i), d);
      chk(d, SMCS_DATA_RST);
    end
    wr_reg(SMCS_DIV_ADDR, 32'hFFFF_0003);
    rd_reg(SMCS_DIV_ADDR, d);
    chk(d, 32'h0000_0003);
    wr_reg(SMCS_DATA1_ADDR, 32'hCAFE_F00D);
    rd_reg(SMCS_DATA1_ADDR, d);
    chk(d, 32'hCAFE_F00D);
    wr_reg(32'hB800_6220, 32'hFFFF_FFFF);
    rd_reg(32'hB800_6220, d);
    chk(d, 32'h0);
  endtask
  task t_manual;
    logic [1:0] b;
    for (int l = 0; l < 2; l++)
      for (int k = 0; k < 3; k++)
      begin
        b = 2'((k + 1) % 3);
        wr_reg(SMCS_SEL_ADDR, {28'h0, 1'b0, l[0], b});
        repeat (2) @(posedge clk);
        #1 chk({30'h0, ss}, {30'h0, l[0] ? b : ~b});
      end
  endtask
  task t_xfer(input logic [15:0] dv, input logic [4:0] len, input logic [1:0] cnt,
              input logic lsb, input logic lvl, input logic [31:0] tx [4],
              input logic fresh, input logic [31:0] wexp);
    logic [31:0] d, mask;
    logic [15:0] r0;
    int          k, n, bits;
    bits = (len == 5'h00) ? 32 : int'(len);
    mask = (bits == 32) ? 32'hFFFF_FFFF : ((32'h1 << bits) - 32'h1);
    lvl_m <= lvl;
    wr_reg(SMCS_DIV_ADDR, {16'h0, dv});
    wr_reg(SMCS_SEL_ADDR, {28'h0, 1'b1, lvl, 2'b01});
    // Skipping the data writes resends what the last transfer received
    if (fresh)
      for (k = 0; k <= cnt; k++)
        wr_reg(SMCS_DATA0_ADDR + 32'(4 * k), tx[k]);
    r0 = rises;
    wr_reg(SMCS_CTRL_ADDR, {21'h0, lsb, cnt, len, 2'b00, 1'b1});
    fork
      begin
        n = 0;
        while (sclk !== 1'b1)
          @(negedge clk);
        chk({31'h0, ss[0]}, {31'h0, lvl});
        while (sclk !== 1'b0)
        begin
          @(negedge clk);
          n++;
        end
        while (sclk !== 1'b1)
        begin
          @(negedge clk);
          n++;
        end
        chk(32'(n), 32'(2 * (dv + 1)));
      end
      begin
        rd_reg(SMCS_CTRL_ADDR, d);
        chk({31'h0, d[0]}, 32'h1);
        wr_reg(SMCS_DATA0_ADDR, 32'h5A5A_5A5A);
        k = 0;
        while (d[0] !== 1'b0 && k < 3000)
        begin
          rd_reg(SMCS_CTRL_ADDR, d);
          k++;
        end
        chk({31'h0, d[0]}, 32'h0);
      end
    join
    chk({30'h0, ss}, {30'h0, lvl ? 2'b00 : 2'b11});
    chk(32'(rises - r0), 32'((cnt + 1) * bits));
    for (k = 0; k <= cnt; k++)
    begin
      rd_reg(SMCS_DATA0_ADDR + 32'(4 * k), d);
      chk(d & mask, ~tx[k] & mask);
    end
    if (cnt == 2'b00)
      chk(mword & mask, wexp);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 32'h0;
    wdata = 32'h0;
    lvl_m = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_manual();
    t_xfer(16'h0001, 5'h08, 2'b00, 1'b0, 1'b0, '{32'h1234_5635, 0, 0, 0}, 1'b1, 32'h35);
    t_xfer(16'h0001, 5'h08, 2'b00, 1'b0, 1'b0, '{32'h1234_56CA, 0, 0, 0}, 1'b0, 32'hCA);
    t_xfer(16'h0002, 5'h08, 2'b00, 1'b1, 1'b1, '{32'h0000_0035, 0, 0, 0}, 1'b1, 32'hAC);
    t_xfer(16'h0001, 5'h1F, 2'b01, 1'b0, 1'b1, '{32'h7FFF_FFFE, 32'h4000_0001, 0, 0}, 1'b1, 32'h0);
    t_xfer(16'h0003, 5'h00, 2'b11, 1'b0, 1'b0,
           '{32'h8000_0001, 32'hFFFF_0000, 32'h0F0F_F0F0, 32'h1234_5678}, 1'b1, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire

// file: sim/smcs_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module smcs_slave_model (
  input  wire logic        clk,
  input  wire logic        sclk,
  input  wire logic [1:0]  ss,
  input  wire logic        level,
  input  wire logic        so,
  output logic             si,
  output logic      [15:0] rises,
  output logic      [31:0] word
);
  logic sclk_q;
  logic flip;
  logic sel;
  assign sel = (ss[0] === level);
  // Echo inverted; a deselected line toggles so stale data cannot match
  assign si = sel ? ~so : flip;
  initial
  begin
    rises  = 16'h0;
    word   = 32'h0;
    flip   = 1'b0;
    sclk_q = 1'b0;
  end
  always @(posedge clk)
  begin
    sclk_q <= sclk;
    flip   <= ~flip;
    if (sel && sclk && !sclk_q)
    begin
      rises <= rises + 16'h1;
      word  <= {word[30:0], so};
    end
  end
endmodule
`default_nettype wire

// file: sim/smcs_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module smcs_top_assertions
  import smcs_pkg::*;
#(
  parameter int DIV_W = SMCS_DIV_W
)(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        SERIAL_CLOCK_OUT,
  input wire logic [1:0]  SLAVE_SELECT_OUT,
  input wire logic        SERIAL_DATA_OUT,
  input wire logic        SERIAL_DATA_IN
);
  // ==========================================================
  // Shadow state
  // Divisor and select are never written mid-transfer by the bench
  logic [DIV_W-1:0] div_q;
  smcs_sel_t        sel_q;
  logic [15:0]      cnt;
  logic             sclk_q;
  logic [1:0]       want;
  assign want = sel_q.select_active_level ? sel_q.select_line_bits : ~sel_q.select_line_bits;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      div_q  <= '0;
      sel_q  <= '0;
      cnt    <= 16'h0;
      sclk_q <= 1'b0;
    end
    else
    begin
      if (WR && ADDR == SMCS_DIV_ADDR)
        div_q <= WDATA[DIV_W-1:0];
      if (WR && ADDR == SMCS_SEL_ADDR)
        sel_q <= WDATA[3:0];
      sclk_q <= SERIAL_CLOCK_OUT;
      cnt    <= (SERIAL_CLOCK_OUT != sclk_q) ? 16'h0 : ((cnt == 16'hFFFF) ? cnt : cnt + 16'h1);
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside read answer");
  a_unmapped_read: assert property (RD && ADDR == 32'hB800_6220 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_divisor_read: assert property (RD && ADDR == SMCS_DIV_ADDR |=> RDATA == 32'(div_q))
    else $error("divisor readback wrong");
  a_select_read: assert property (RD && ADDR == SMCS_SEL_ADDR |=> RDATA == 32'(sel_q))
    else $error("select readback wrong");
  a_sclk_half: assert property ($fell(SERIAL_CLOCK_OUT) |-> cnt == 16'(div_q))
    else $error("serial clock high phase length wrong");
  // Select output lags the register by one cycle, so check once the shadow is stable
  a_sel_manual: assert property (!sel_q.auto_select_enable && $stable(sel_q)
      |-> SLAVE_SELECT_OUT == want)
    else $error("manual select output wrong");
  a_sel_word: assert property (sel_q.auto_select_enable && SERIAL_CLOCK_OUT
      |-> SLAVE_SELECT_OUT == want)
    else $error("auto select not active during word");
  a_sel_unused: assert property ($stable(sel_q)
      |-> ((SLAVE_SELECT_OUT ^ {2{~sel_q.select_active_level}})
           & ~sel_q.select_line_bits) == 2'b00)
    else $error("unselected line driven active");
  c_auto_word: cover property (sel_q.auto_select_enable && $rose(SERIAL_CLOCK_OUT));
  c_last_word: cover property (RD && ADDR == SMCS_DATA3_ADDR);
  c_slow_clock: cover property ($fell(SERIAL_CLOCK_OUT) && div_q == 3);
endmodule

bind smcs_top smcs_top_assertions #(.DIV_W(DIV_W)) u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT),
  .SLAVE_SELECT_OUT(SLAVE_SELECT_OUT), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .SERIAL_DATA_IN(SERIAL_DATA_IN));
`default_nettype wire
